// File: pss_consts.svh
/*
 page register set selector: constants for offsets, field positions, reset values and counts.
 assumes inclusion by bare name from every file of the selector except the package.
*/
//
// Overview of operation
// - forty-eight base and descriptor registers form pairs, read together on one bus.
// - each privilege mode owns sixteen pairs, eight instruction, eight data space.
// - virtual address bits 15 to 13 pick one of eight pairs.
// - a lookup table indexed by microprogram state yields sixteen condition bits.
// - lookup bits 1 to 3 are decoded and registered on the timing-two pulse.
// - three mode flip-flops update at end of T1 of bus starts, drive chip selects.
// - console examine or deposit takes the mode from the console switch.
// - kernel data-in cycle forces kernel mode, status bits untouched.
// - previous-move execute cycle loads previous-mode status bits into mode flops.
// - otherwise current-mode bits select; supervisor or user need no kernel data-in.
// - per-mode space line high for instruction; data needs enable bit and no forcing.
// - instruction forcing flags register at end of T1 in bus starts.
// - console with the space switch set, fetch, float immediate and absolute address words force instruction space.
// - source modes 1 to 5 with source register 7 force instruction space.
// - write completing read-pause uses instruction space if the read did.
// - previous-move instruction-space destinations force instruction, except user-user move-from.
// - destination mode 1 or 2 with register 7, not previous-move, forces instruction.
// - without direct register access, mode flops drive both chip select groups.
// - without direct register access, pair bits come from address mux 15:13, plus an unbuffered fast copy.
// - lookup bit 4 with maintenance bit enables relocation in execute cycles.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_LUT_ABITS   8
`define PSS_LUT_DEPTH   256
`define PSS_PAIRS       48
`define PSS_MODES       3

// lookup output bit positions
`define PSS_LO_DSTM     4
`define PSS_LO_PREV     5
`define PSS_LO_KDATI    6
`define PSS_LO_BUS_START_CYCLE     7
`define PSS_LO_IFMTP    8
`define PSS_LO_IFETCH   9
`define PSS_LO_RPW      11
`define PSS_LO_CNSL     12
`define PSS_LO_SRCM     13
`define PSS_LO_DSTM12   14
`define PSS_LO_DSTM3    15
`define PSS_LO_FPIMM    16

// status word and instruction fields
`define PSS_PSW_CUR_HI  15
`define PSS_PSW_CUR_LO  14
`define PSS_PSW_PRV_HI  13
`define PSS_PSW_PRV_LO  12
`define PSS_IR_OPC15    15
`define PSS_IR_MFROM    7
`define PSS_IR_SRC_HI   8
`define PSS_IR_SRC_LO   6
`define PSS_IR_DMD_HI   5
`define PSS_IR_DMD_LO   3
`define PSS_IR_DST_HI   2
`define PSS_IR_DST_LO   0
`define PSS_REG_SEVEN   3'h7
`define PSS_DMODE_TWO   3'h2

// mode codes in the status word
`define PSS_CODE_KERNEL 2'h0
`define PSS_CODE_SUPER  2'h1
`define PSS_CODE_USER   2'h3

// reset values
`define PSS_RST_SEL3    3'h0
`define PSS_RST_DEC8    8'h00
`define PSS_RST_IDX6    6'h00

`endif

// File: pss_pkg.sv
/*
 page register set selector: shared types.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pss_pkg;
    typedef enum logic [2:0] {
        pss_mode_none   = 3'b000,
        pss_mode_kernel = 3'b001,
        pss_mode_super  = 3'b010,
        pss_mode_user   = 3'b100
    } pss_mode_t;
endpackage

// File: pss_lut_if.sv
/*
 page register set selector: carrier between the selector and its lookup store.
 assumes pss_consts.svh is on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_consts.svh"
interface pss_lut_if;
    logic [`PSS_LUT_ABITS-1:0] rd_addr;
    logic [16:1]               rd_data;
    logic                      wr_en;
    logic [`PSS_LUT_ABITS-1:0] wr_addr;
    logic [16:1]               wr_data;
    modport client (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport store  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// File: pss_lut_store.sv
/*
 page register set selector: condition lookup store, one word per microprogram state.
 assumes a single clock; contents are loaded through the write port before use.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_consts.svh"
module pss_lut_store #(
    parameter int DEPTH = `PSS_LUT_DEPTH
) (
    input  wire logic clk,
    pss_lut_if.store  lut
);
    // every microprogram state needs a word of its own
    if (DEPTH != (1 << `PSS_LUT_ABITS)) begin : g_bad_depth
        $error("lookup depth must match the state address space");
    end

    logic [16:1] mem [DEPTH];

    // read data comes from a register: one cycle after the state address
    always_ff @(posedge clk) begin
        if (lut.wr_en) begin
            mem[lut.wr_addr] <= lut.wr_data;
        end
        lut.rd_data <= mem[lut.rd_addr];
    end
endmodule // pss_lut_store
`default_nettype wire

// File: pss_selector.sv
/*
 page register set selector: picks the base/descriptor register pair for each bus cycle.
 assumes sequencer strobes and status inputs come from logic on clk; console switches are pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_consts.svh"
module pss_selector #(
    parameter int PAIRS = `PSS_PAIRS
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic [`PSS_LUT_ABITS-1:0] ustate_addr,
    input  wire logic                      t1_end,
    input  wire logic                      t2_pulse,
    input  wire logic [15:0]               processor_status_word,
    input  wire logic [15:0]               instr_reg,
    input  wire logic                      previous_move_decode,
    input  wire logic [2:0]                bus_address_mux,
    input  wire logic [2:0]                dspace_en,
    input  wire logic                      reloc_en,
    input  wire logic                      maint_dst_en,
    input  wire logic                      direct_register_access,
    input  wire logic [2:0]                direct_cs,
    input  wire logic [2:0]                direct_pair,
    input  wire logic [2:0]                cnsl_mode_sw,
    input  wire logic                      cnsl_ispace_sw,
    input  wire logic                      lut_wr_en,
    input  wire logic [`PSS_LUT_ABITS-1:0] lut_wr_addr,
    input  wire logic [16:1]               lut_wr_data,
    output logic [2:0]                     page_base_cs,
    output logic [2:0]                     page_desc_cs,
    output logic [2:0]                     space_select_line,
    output logic [2:0]                     pair_select_bits,
    output logic [2:0]                     pair_select_fast,
    output logic [5:0]                     pair_index,
    output logic                           reloc_active,
    output logic [7:0]                     lookup_decode
);
    // chip selects and the pair index assume exactly three modes of sixteen pairs
    if (PAIRS != `PSS_MODES * 16) begin : g_bad_pairs
        $error("pair count must be sixteen per mode");
    end

    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    function automatic pss_pkg::pss_mode_t code_to_mode(input logic [1:0] code);
        case (code)
            `PSS_CODE_KERNEL: code_to_mode = pss_pkg::pss_mode_kernel;
            `PSS_CODE_SUPER:  code_to_mode = pss_pkg::pss_mode_super;
            `PSS_CODE_USER:   code_to_mode = pss_pkg::pss_mode_user;
            default:          code_to_mode = pss_pkg::pss_mode_none;
        endcase
    endfunction

    function automatic logic [1:0] mode_to_group(input logic [2:0] m);
        case (m)
            3'h2:    mode_to_group = 2'h1;
            3'h4:    mode_to_group = 2'h2;
            default: mode_to_group = 2'h0;
        endcase
    endfunction

    //--------------------------------------------------------------
    // lookup store and console pin synchronisers
    //--------------------------------------------------------------
    pss_lut_if lut ();
    assign lut.rd_addr = ustate_addr;
    assign lut.wr_en   = lut_wr_en;
    assign lut.wr_addr = lut_wr_addr;
    assign lut.wr_data = lut_wr_data;

    pss_lut_store #(.DEPTH(`PSS_LUT_DEPTH)) u_store (
        .clk (clk),
        .lut (lut)
    );

    logic [16:1] lo;
    assign lo = lut.rd_data;

    // console switches are asynchronous pins: two flops guard against metastability
    logic [3:0] cnsl_meta;
    logic [3:0] cnsl_sync;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnsl_meta <= 4'h0;
            cnsl_sync <= 4'h0;
        end else begin
            cnsl_meta <= {cnsl_ispace_sw, cnsl_mode_sw};
            cnsl_sync <= cnsl_meta;
        end
    end

    //--------------------------------------------------------------
    // decision logic
    //--------------------------------------------------------------
    logic       cur_user;
    logic       prv_user;
    logic       srcf7;
    logic       dstf7;
    logic       dstm2;
    logic       space_clk;
    logic       ispace_a;
    logic       ispace_b;
    logic [2:0] mode_q;
    logic       ispace_q;
    logic       dst_q;
    logic [7:0] dec_q;
    logic [2:0] next_mode;
    logic       next_ispace;
    logic       next_dst;
    logic [7:0] next_dec;

    assign cur_user  = processor_status_word[`PSS_PSW_CUR_HI:`PSS_PSW_CUR_LO] == `PSS_CODE_USER;
    assign prv_user  = processor_status_word[`PSS_PSW_PRV_HI:`PSS_PSW_PRV_LO] == `PSS_CODE_USER;
    assign srcf7     = instr_reg[`PSS_IR_SRC_HI:`PSS_IR_SRC_LO] == `PSS_REG_SEVEN;
    assign dstf7     = instr_reg[`PSS_IR_DST_HI:`PSS_IR_DST_LO] == `PSS_REG_SEVEN;
    assign dstm2     = instr_reg[`PSS_IR_DMD_HI:`PSS_IR_DMD_LO] == `PSS_DMODE_TWO;
    // update strobe: trailing edge of T1 in a bus start
    assign space_clk = t1_end & lo[`PSS_LO_BUS_START_CYCLE];

    always_comb begin
        ispace_a = (lo[`PSS_LO_CNSL] & cnsl_sync[3])
                 | lo[`PSS_LO_IFETCH]
                 | (lo[`PSS_LO_FPIMM] & dstm2 & dstf7)
                 | (lo[`PSS_LO_DSTM3] & dstf7);
        ispace_b = (lo[`PSS_LO_SRCM] & srcf7)
                 // read-pause write stays in the read's space
                 | (lo[`PSS_LO_RPW] & ispace_q)
                 | (lo[`PSS_LO_IFMTP] & previous_move_decode & ~instr_reg[`PSS_IR_OPC15]
                    & ~(~instr_reg[`PSS_IR_MFROM] & cur_user & prv_user))
                 // destination mode 1 or 2 with register seven
                 | (lo[`PSS_LO_DSTM12] & dstf7 & ~previous_move_decode);

        next_mode   = mode_q;
        next_ispace = ispace_q;
        next_dst    = dst_q;
        next_dec    = dec_q;
        if (space_clk) begin
            if (lo[`PSS_LO_CNSL]) begin
                next_mode = cnsl_sync[2:0];
            end else if (lo[`PSS_LO_KDATI]) begin
                next_mode = pss_pkg::pss_mode_kernel;
            end else if (lo[`PSS_LO_PREV]) begin
                next_mode = code_to_mode(processor_status_word[`PSS_PSW_PRV_HI:`PSS_PSW_PRV_LO]);
            end else begin
                next_mode = code_to_mode(processor_status_word[`PSS_PSW_CUR_HI:`PSS_PSW_CUR_LO]);
            end
            next_ispace = ispace_a | ispace_b;
            next_dst    = lo[`PSS_LO_DSTM];
        end
        if (t2_pulse) begin
            next_dec = 8'h01 << lo[3:1];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q   <= `PSS_RST_SEL3;
            ispace_q <= 1'b0;
            dst_q    <= 1'b0;
            dec_q    <= `PSS_RST_DEC8;
        end else begin
            mode_q   <= next_mode;
            ispace_q <= next_ispace;
            dst_q    <= next_dst;
            dec_q    <= next_dec;
        end
    end

    //--------------------------------------------------------------
    // select outputs
    //--------------------------------------------------------------
    logic [2:0] next_cs;
    logic [2:0] next_space;
    logic [2:0] next_pair;
    logic [5:0] next_index;
    logic       next_reloc;
    logic [2:0] space_data;

    // one data-space request per mode, enable gated by the forcing flag
    for (genvar m = 0; m < `PSS_MODES; m++) begin : g_space
        assign space_data[m] = dspace_en[m] & ~ispace_q;
    end

    always_comb begin
        // relocation input of the chip select multiplexers
        next_cs    = direct_register_access ? direct_cs : mode_q;
        // data space only when enabled and not forced
        next_space = ~space_data;
        // pair bits from the address mux
        next_pair  = direct_register_access ? direct_pair : bus_address_mux;
        // flat pair number: mode group, space, page
        next_index = {mode_to_group(mode_q), 4'h0} + {2'h0, ~next_space[mode_to_group(mode_q)], next_pair};
        // relocation in execute cycles under maintenance
        next_reloc = reloc_en | (maint_dst_en & dst_q);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page_base_cs      <= `PSS_RST_SEL3;
            page_desc_cs      <= `PSS_RST_SEL3;
            space_select_line <= `PSS_RST_SEL3;
            pair_select_bits  <= `PSS_RST_SEL3;
            pair_select_fast  <= `PSS_RST_SEL3;
            pair_index        <= `PSS_RST_IDX6;
            reloc_active      <= 1'b0;
            lookup_decode     <= `PSS_RST_DEC8;
        end else begin
            // extra register stage: every output comes from a flop, at one cycle of latency
            page_base_cs      <= next_cs;
            page_desc_cs      <= next_cs;
            space_select_line <= next_space;
            pair_select_bits  <= next_pair;
            pair_select_fast  <= next_pair;
            pair_index        <= next_index;
            reloc_active      <= next_reloc;
            lookup_decode     <= dec_q;
        end
    end

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_console_mode_take: assert property (space_clk && lo[`PSS_LO_CNSL] |=> mode_q == $past(cnsl_sync[2:0]))
        else $error("console cycle did not take switch mode");
    a_kernel_force_read_word_cycle: assert property (space_clk && !lo[`PSS_LO_CNSL] && lo[`PSS_LO_KDATI]
                                          |=> mode_q == pss_pkg::pss_mode_kernel)
        else $error("kernel data-in did not force kernel");
    a_prev_mode_load: assert property (space_clk && !lo[`PSS_LO_CNSL] && !lo[`PSS_LO_KDATI]
        && lo[`PSS_LO_PREV]
        |=> mode_q == code_to_mode($past(processor_status_word[`PSS_PSW_PRV_HI:`PSS_PSW_PRV_LO])))
        else $error("previous mode not loaded");
    a_cur_mode_select: assert property (space_clk && !lo[`PSS_LO_CNSL] && !lo[`PSS_LO_KDATI]
        && !lo[`PSS_LO_PREV]
        |=> mode_q == code_to_mode($past(processor_status_word[`PSS_PSW_CUR_HI:`PSS_PSW_CUR_LO])))
        else $error("current mode not selected");
    a_mode_holds_idle: assert property (!space_clk |=> $stable(mode_q) && $stable(ispace_q))
        else $error("selection moved outside a bus start");
    a_cs_follow_mode: assert property (!direct_register_access |=> page_base_cs == $past(mode_q)
                                       && page_desc_cs == $past(mode_q))
        else $error("chip selects do not follow mode");

    a_fetch_forces_i: assert property (space_clk && lo[`PSS_LO_IFETCH] |=> ##1 space_select_line == 3'h7)
        else $error("fetch did not force instruction space");
    a_console_ispace: assert property (space_clk && lo[`PSS_LO_CNSL] && cnsl_sync[3] |=> ispace_q)
        else $error("console switch did not force instruction space");
    a_src_seven_force: assert property (space_clk && lo[`PSS_LO_SRCM] && srcf7 |=> ispace_q)
        else $error("source register seven not in instruction space");
    a_rpw_same_space: assert property (space_clk && lo[`PSS_LO_RPW] && ispace_q |=> ispace_q)
        else $error("read-pause write left instruction space");
    a_prev_dest_ispace: assert property (space_clk && lo[`PSS_LO_IFMTP] && previous_move_decode
        && !instr_reg[`PSS_IR_OPC15] && (instr_reg[`PSS_IR_MFROM] || !(cur_user && prv_user)) |=> ispace_q)
        else $error("previous-move destination not in instruction space");
    a_dst_seven_force: assert property (space_clk && lo[`PSS_LO_DSTM12] && dstf7 && !previous_move_decode
                                        |=> ispace_q)
        else $error("destination register seven not in instruction space");
    // data space needs enable; the line holds its reset value one edge after release
    a_dspace_needs_en: assert property ($past(rst_b) && space_select_line[0] == 1'b0
                                        |-> $past(dspace_en[0], 1) && !$past(ispace_q, 1))
        else $error("data space chosen without enable");

    a_decode_onehot: assert property (t2_pulse |=> dec_q == (8'h01 << $past(lo[3:1]))
                                      ##1 lookup_decode == $past(dec_q))
        else $error("lookup decode wrong");
    a_decode_holds: assert property (!t2_pulse |=> $stable(dec_q))
        else $error("lookup decode moved without a timing-two pulse");
    a_pair_from_mux: assert property (!direct_register_access |=> pair_select_bits == $past(bus_address_mux)
                                      && pair_select_fast == pair_select_bits)
        else $error("pair bits do not follow address mux");
    a_user_index: assert property (!direct_register_access && mode_q == pss_pkg::pss_mode_user
        |=> pair_index[5:4] == 2'h2 && pair_index[3] == ($past(dspace_en[2]) && !$past(ispace_q))
            && pair_index[2:0] == $past(bus_address_mux))
        else $error("user pair index wrong");
    a_maint_reloc: assert property (space_clk && lo[`PSS_LO_DSTM] && maint_dst_en && !reloc_en
                                    |=> ##1 reloc_active)
        else $error("maintenance relocation not enabled");
endmodule // pss_selector
`default_nettype wire

// File: pss_seq_model.sv
/*
 page register set selector: model of the microprogram sequencer feeding the selector.
 assumes the selector's lookup load port and timing strobes, all on clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_consts.svh"
module pss_seq_model (
    input  wire logic                      clk,
    output logic [`PSS_LUT_ABITS-1:0]      ustate_addr,
    output logic                           t1_end,
    output logic                           t2_pulse,
    output logic                           lut_wr_en,
    output logic [`PSS_LUT_ABITS-1:0]      lut_wr_addr,
    output logic [16:1]                    lut_wr_data
);
    initial begin
        ustate_addr = 8'h00;
        t1_end      = 1'b0;
        t2_pulse    = 1'b0;
        lut_wr_en   = 1'b0;
        lut_wr_addr = 8'h00;
        lut_wr_data = 16'h0000;
    end

    // ----------------------------------------------
    // one microprogram state with its timing strobes
    // ----------------------------------------------
    task automatic step(input logic [7:0] st, input logic [16:1] word);
        @(posedge clk);
        lut_wr_en   <= 1'b1;
        lut_wr_addr <= st;
        lut_wr_data <= word;
        @(posedge clk);
        lut_wr_en   <= 1'b0;
        ustate_addr <= st;
        // released load lines show the inverse, never a stale copy
        lut_wr_addr <= ~st;
        lut_wr_data <= ~word;
        @(posedge clk);
        t1_end      <= 1'b1;
        t2_pulse    <= 1'b1;
        @(posedge clk);
        t1_end      <= 1'b0;
        t2_pulse    <= 1'b0;
    endtask
endmodule // pss_seq_model
`default_nettype wire

// File: page_register_set_selector_test.sv
/*
 page register set selector: self-checking testbench.
 assumes pss_selector, pss_lut_store and pss_seq_model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_consts.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module page_register_set_selector_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  ustate_addr;
    logic        t1_end, t2_pulse, lut_wr_en;
    logic [7:0]  lut_wr_addr;
    logic [16:1] lut_wr_data;
    logic [15:0] processor_status_word = 16'h0000;
    logic [15:0] instr_reg = 16'h0000;
    logic        previous_move_decode = 1'b0;
    logic [2:0]  bus_address_mux = 3'h0;
    logic [2:0]  dspace_en = 3'h0;
    logic        reloc_en = 1'b0;
    logic        maint_dst_en = 1'b0;
    logic        direct_register_access = 1'b0;
    logic [2:0]  direct_cs = 3'h0;
    logic [2:0]  direct_pair = 3'h0;
    logic [2:0]  cnsl_mode_sw = 3'h0;
    logic        cnsl_ispace_sw = 1'b0;
    logic [2:0]  page_base_cs, page_desc_cs, space_select_line, pair_select_bits, pair_select_fast;
    logic [5:0]  pair_index;
    logic        reloc_active;
    logic [7:0]  lookup_decode;
    int          n_mismatch = 0;
    int          num_checks = 0;
    logic [7:0]  n = 8'h01;
    logic        last_lo4 = 1'b0;
    logic [2:0]  last_cs = 3'h0;

    pss_selector #(.PAIRS(48)) dut (.clk(clk), .rst_b(rst_b), .ustate_addr(ustate_addr), .t1_end(t1_end),
        .t2_pulse(t2_pulse), .processor_status_word(processor_status_word), .instr_reg(instr_reg),
        .previous_move_decode(previous_move_decode), .bus_address_mux(bus_address_mux),
        .dspace_en(dspace_en), .reloc_en(reloc_en), .maint_dst_en(maint_dst_en),
        .direct_register_access(direct_register_access), .direct_cs(direct_cs), .direct_pair(direct_pair),
        .cnsl_mode_sw(cnsl_mode_sw), .cnsl_ispace_sw(cnsl_ispace_sw), .lut_wr_en(lut_wr_en),
        .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data), .page_base_cs(page_base_cs),
        .page_desc_cs(page_desc_cs), .space_select_line(space_select_line),
        .pair_select_bits(pair_select_bits), .pair_select_fast(pair_select_fast),
        .pair_index(pair_index), .reloc_active(reloc_active), .lookup_decode(lookup_decode));

    pss_seq_model seq (.clk(clk), .ustate_addr(ustate_addr), .t1_end(t1_end), .t2_pulse(t2_pulse),
        .lut_wr_en(lut_wr_en), .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------
    // one sequencer state; w bit k-1 is lookup bit k from bit 4 up, bits 1 to 3 come from n
    // ----------------------------------------------
    task automatic row(input logic [15:0] w, input logic [15:0] psw, input logic [15:0] ir,
                       input logic pm, input logic sw, input logic [2:0] ecs, input logic eis);
        logic [2:0] dsp;
        logic [2:0] bx;
        logic [1:0] grp;
        dsp = n[2:0];
        bx  = n[2:0] + 3'h3;
        @(posedge clk);
        processor_status_word <= psw;
        instr_reg             <= ir;
        previous_move_decode  <= pm;
        cnsl_ispace_sw        <= sw;
        // the switch holds the expected mode rotated by one bit unless a console state reads it
        cnsl_mode_sw          <= w[11] ? ecs : {ecs[1:0], ecs[2]};
        dspace_en             <= dsp;
        bus_address_mux       <= bx;
        maint_dst_en          <= n[0];
        seq.step(n, {w[15:3], n[2:0]});
        if (w[6]) begin
            last_lo4 = w[3];
        end
        repeat (2) @(posedge clk);
        #1;
        grp = ecs[2] ? 2'h2 : (ecs[1] ? 2'h1 : 2'h0);
        `CHK("base_cs", ecs, page_base_cs)
        `CHK("desc_cs", ecs, page_desc_cs)
        `CHK("space_line", ~dsp | {3{eis}}, space_select_line)
        `CHK("pair_bits", bx, pair_select_bits)
        `CHK("pair_fast", bx, pair_select_fast)
        `CHK("decode", 8'h01 << n[2:0], lookup_decode)
        `CHK("reloc", n[0] & last_lo4, reloc_active)
        if (ecs != 3'h0) `CHK("pair_index", {grp, dsp[grp] & ~eis, bx}, pair_index)
        last_cs = ecs;
        n = n + 8'h01;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("reset_cs", 3'h0, page_base_cs)
        `CHK("reset_space", 3'h7, space_select_line)
        row(16'h0040, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h1, 1'b0);
        row(16'h0040, 16'h4000, 16'h0000, 1'b0, 1'b0, 3'h2, 1'b0);
        row(16'h0040, 16'hC000, 16'h0000, 1'b0, 1'b0, 3'h4, 1'b0);
        row(16'h0040, 16'h8000, 16'h0000, 1'b0, 1'b0, 3'h0, 1'b0);
        row(16'h0068, 16'hC000, 16'h0000, 1'b0, 1'b0, 3'h1, 1'b0);
        row(16'h0050, 16'hD000, 16'h0000, 1'b0, 1'b0, 3'h2, 1'b0);
        row(16'h0840, 16'h0000, 16'h0000, 1'b0, 1'b1, 3'h4, 1'b1);
        row(16'h0840, 16'hC000, 16'h0000, 1'b0, 1'b0, 3'h2, 1'b0);
        row(16'h0148, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h1, 1'b1);
        row(16'h0440, 16'h4000, 16'h0000, 1'b0, 1'b0, 3'h2, 1'b1);
        row(16'h8040, 16'h0000, 16'h0017, 1'b0, 1'b0, 3'h1, 1'b1);
        row(16'h8040, 16'h0000, 16'h000F, 1'b0, 1'b0, 3'h1, 1'b0);
        row(16'h0440, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h1, 1'b0);
        row(16'h4040, 16'h0000, 16'h0007, 1'b0, 1'b0, 3'h1, 1'b1);
        row(16'h1040, 16'h0000, 16'h01C0, 1'b0, 1'b0, 3'h1, 1'b1);
        row(16'h1040, 16'h0000, 16'h0180, 1'b0, 1'b0, 3'h1, 1'b0);
        row(16'h00C0, 16'hF000, 16'h0080, 1'b1, 1'b0, 3'h4, 1'b1);
        row(16'h00C0, 16'hF000, 16'h0000, 1'b1, 1'b0, 3'h4, 1'b0);
        row(16'h00C0, 16'h3000, 16'h0000, 1'b1, 1'b0, 3'h1, 1'b1);
        row(16'h00C0, 16'h0000, 16'h8080, 1'b1, 1'b0, 3'h1, 1'b0);
        row(16'h2040, 16'h0000, 16'h0007, 1'b0, 1'b0, 3'h1, 1'b1);
        row(16'h2040, 16'h0000, 16'h8007, 1'b1, 1'b0, 3'h1, 1'b0);
        // no bus-start bit: selection must hold
        row(16'h0108, 16'hC000, 16'h0000, 1'b0, 1'b1, 3'h1, 1'b0);
        @(posedge clk);
        direct_register_access <= 1'b1;
        direct_cs              <= 3'h2;
        direct_pair            <= 3'h5;
        reloc_en               <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("direct_cs", 3'h2, page_base_cs)
        `CHK("direct_pair", 3'h5, pair_select_bits)
        `CHK("reloc_on", 1'b1, reloc_active)
        @(posedge clk);
        direct_register_access <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("back_cs", last_cs, page_desc_cs)
        test_done();
    end
endmodule // page_register_set_selector_test
`default_nettype wire
